// *** hw/bit_timer.sv ***
// Bit period timer: mid-bit and end-of-bit strobes
`timescale 1ns/1ps
module bit_timer
  import uart_pkg::*;
#(
  parameter int DIV_K = DIV_K_DEFAULT
) (
  input wire logic clk,
  input wire logic sys_rst,
  bit_timer_if.timer tmr
);

  // ----------------------------------------------------------------
  // One bit lasts two divider periods
  // ----------------------------------------------------------------
  localparam logic [8:0] FULL_LAST = 9'(2 * DIV_K - 1);
  localparam logic [8:0] MID_LAST = 9'(DIV_K - 1);

  if (DIV_K < DIV_K_MIN || DIV_K > DIV_K_MAX) begin : g_bad_div
    $error("bit_timer: DIV_K out of range");
  end

  logic [8:0] cnt_q;

  assign tmr.full = (cnt_q == FULL_LAST);
  assign tmr.mid = (cnt_q == MID_LAST);

  always_ff @(posedge clk) begin
    if (sys_rst || tmr.clr || tmr.full) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 9'h001;
    end
  end

endmodule : bit_timer

// *** hw/bit_timer_if.sv ***
// Bit timing handshake between a shifter and its bit timer
`timescale 1ns/1ps
interface bit_timer_if;
  logic clr;
  logic mid;
  logic full;
  modport owner (output clr, input mid, input full);
  modport timer (input clr, output mid, output full);
endinterface : bit_timer_if

// *** hw/serial_transceiver.sv ***
// Asynchronous serial transceiver with 8-bit register port
`timescale 1ns/1ps
module serial_transceiver
  import uart_pkg::*;
#(
  parameter int DIV_K = DIV_K_DEFAULT
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  input wire logic transmit_invert,
  input wire logic msb_first,
  output logic transmit_done_irq,
  output logic receive_done_irq,
  output logic receive_error_irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] mode_q, txb_q, rxb_q, rdata_q, txs_q, txs_d, rxs_q, rxs_d;
  logic [2:0] err_q, err_now;
  logic tx_en_q, rx_en_q, err_armed_q, rxb_full_q;
  logic tx_line_q, tx_line_d, tx_par_q, tx_par_d, txbf_q, txbf_d, tx_done_d;
  logic rx_par_q, rx_par_d, rx_perr_q, rx_perr_d;
  logic [3:0] tx_cnt_q, tx_cnt_d, rx_cnt_q, rx_cnt_d;
  logic out_q, tx_irq_q, rx_irq_q, rxe_irq_q;
  tx_state_t tx_state_q, tx_state_d;
  rx_state_t rx_state_q, rx_state_d;
  bit_timer_if tx_t ();
  bit_timer_if rx_t ();

  bit_timer #(.DIV_K(DIV_K)) u_tx_timer (.clk(clk), .sys_rst(sys_rst), .tmr(tx_t));
  bit_timer #(.DIV_K(DIV_K)) u_rx_timer (.clk(clk), .sys_rst(sys_rst), .tmr(rx_t));

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire power = mode_q[MODE_POWER];
  wire tx_run = power && tx_en_q;
  wire rx_run = power && rx_en_q;
  wire [1:0] par_mode = mode_q[MODE_PAR_HI:MODE_PAR_LO];
  wire [3:0] last_bit = mode_q[MODE_CL] ? LAST_BIT_8 : LAST_BIT_7;
  wire [1:0] last_stop = mode_q[MODE_SL] ? LAST_STOP_2 : LAST_STOP_1;
  wire wr_mode = reg_wr && (reg_addr == ADDR_MODE);
  wire wr_txb = reg_wr && (reg_addr == ADDR_TXB);
  wire rd_rxb = reg_rd && (reg_addr == ADDR_RXB);
  wire rd_err = reg_rd && (reg_addr == ADDR_ERR);
  // Receiver sees a quiet line while the unit is off
  wire rx_in = power ? serial_in_pin : 1'b1;
  wire tx_bit = msb_first ? txs_q[7] : txs_q[0];
  wire [7:0] txs_shift = msb_first ? {txs_q[6:0], 1'b1} : {1'b1, txs_q[7:1]};
  wire [7:0] rxs_shift = msb_first ? {rxs_q[6:0], rx_in} : {rx_in, rxs_q[7:1]};
  wire tx_par_bit = (par_mode == PAR_ODD) ? ~tx_par_q :
                    (par_mode == PAR_EVEN) ? tx_par_q : 1'b0;
  wire rx_par_sum = rx_par_q ^ rx_in;
  wire rx_par_bad = (par_mode == PAR_ODD) ? ~rx_par_sum :
                    (par_mode == PAR_EVEN) ? rx_par_sum : 1'b0;
  wire [7:0] rx_word = mode_q[MODE_CL] ? rxs_q :
                       msb_first ? {rxs_q[6:0], 1'b0} :
                       {1'b0, rxs_q[7:1]};
  wire rx_end = (rx_state_q == RX_STOP) && rx_t.mid;
  wire ove_now = rxb_full_q && !rd_rxb;
  wire rx_load = rx_end && !ove_now;
  wire err_any = |err_now;
  wire err_clr = rd_rxb && err_armed_q;
  wire txsf = (tx_state_q != TX_IDLE);
  wire tx_take_next = txbf_q || wr_txb;
  wire [7:0] tx_next = txbf_q ? txb_q : reg_wdata;
  wire [7:0] rd_mux = (reg_addr == ADDR_MODE) ? mode_q :
                      (reg_addr == ADDR_TXB) ? txb_q :
                      (reg_addr == ADDR_RXB) ? rxb_q :
                      (reg_addr == ADDR_ERR) ? {ERR_PAD, err_q} :
                      (reg_addr == ADDR_TXST) ? {TXST_PAD, txbf_q, txsf} : RD_UNMAPPED;

  assign err_now = {rx_perr_q, ~rx_in, ove_now};
  assign tx_t.clr = !tx_run || (tx_state_q == TX_IDLE);
  assign rx_t.clr = !rx_run || (rx_state_q == RX_IDLE);
  assign reg_rdata = rdata_q;
  assign serial_out_pin = out_q;
  assign transmit_done_irq = tx_irq_q;
  assign receive_done_irq = rx_irq_q;
  assign receive_error_irq = rxe_irq_q;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode_q <= MODE_RST;
    end else if (wr_mode) begin
      mode_q <= reg_wdata;
    end
  end

  // Enables pass one flop so a half never starts mid-write
  always_ff @(posedge clk) begin
    tx_en_q <= !sys_rst && power && mode_q[MODE_TXE];
    rx_en_q <= !sys_rst && power && mode_q[MODE_RXE];
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      txb_q <= BUF_RST;
    end else if (wr_txb) begin
      txb_q <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_q <= RD_UNMAPPED;
    end else if (reg_rd) begin
      rdata_q <= rd_mux;
    end
  end

  // Receive buffer and error status; a new error beats a clearing read
  always_ff @(posedge clk) begin
    if (sys_rst || !power) begin
      rxb_q <= BUF_RST;
      rxb_full_q <= 1'b0;
      err_q <= ERR_CLEAR;
      err_armed_q <= 1'b0;
    end else begin
      if (rx_load) begin
        rxb_q <= rx_word;
      end
      rxb_full_q <= rx_load || (rxb_full_q && !rd_rxb);
      err_q <= !rx_run ? ERR_CLEAR :
               ((err_clr ? ERR_CLEAR : err_q) | (rx_end ? err_now : ERR_CLEAR));
      err_armed_q <= rd_err || (err_armed_q && !rd_rxb);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      out_q <= 1'b1;
      tx_irq_q <= 1'b0;
      rx_irq_q <= 1'b0;
      rxe_irq_q <= 1'b0;
    end else begin
      out_q <= (power ? tx_line_q : 1'b1) ^ transmit_invert;
      tx_irq_q <= tx_done_d;
      rx_irq_q <= rx_end && (!err_any || mode_q[MODE_ISRM]);
      rxe_irq_q <= rx_end && err_any && !mode_q[MODE_ISRM];
    end
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  always_comb begin
    tx_state_d = tx_state_q;
    tx_cnt_d = tx_cnt_q;
    txs_d = txs_q;
    tx_line_d = tx_line_q;
    tx_par_d = tx_par_q;
    txbf_d = txbf_q || (wr_txb && txsf);
    tx_done_d = 1'b0;
    unique case (tx_state_q)
      TX_IDLE: begin
        if (wr_txb) begin
          txs_d = reg_wdata;
          tx_line_d = 1'b0;
          tx_state_d = TX_START;
        end
      end
      TX_START: begin
        if (tx_t.full) begin
          tx_line_d = tx_bit;
          tx_par_d = tx_bit;
          txs_d = txs_shift;
          tx_cnt_d = '0;
          tx_state_d = TX_DATA;
        end
      end
      TX_DATA: begin
        if (tx_t.full && tx_cnt_q == last_bit) begin
          tx_cnt_d = '0;
          tx_line_d = (par_mode == PAR_NONE) ? 1'b1 : tx_par_bit;
          tx_state_d = (par_mode == PAR_NONE) ? TX_STOP : TX_PAR;
        end else if (tx_t.full) begin
          tx_line_d = tx_bit;
          tx_par_d = tx_par_q ^ tx_bit;
          txs_d = txs_shift;
          tx_cnt_d = tx_cnt_q + 4'h1;
        end
      end
      TX_PAR: begin
        if (tx_t.full) begin
          tx_line_d = 1'b1;
          tx_state_d = TX_STOP;
        end
      end
      TX_STOP: begin
        if (tx_t.full && tx_cnt_q[1:0] == last_stop) begin
          tx_done_d = 1'b1;
          tx_cnt_d = '0;
          txbf_d = 1'b0;
          if (tx_take_next) begin
            txs_d = tx_next;
            tx_line_d = 1'b0;
            tx_state_d = TX_START;
          end else begin
            tx_state_d = TX_IDLE;
          end
        end else if (tx_t.full) begin
          tx_cnt_d = tx_cnt_q + 4'h1;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst || !tx_run) begin
      tx_state_q <= TX_IDLE;
      tx_cnt_q <= '0;
      txs_q <= BUF_RST;
      tx_line_q <= 1'b1;
      tx_par_q <= 1'b0;
      txbf_q <= 1'b0;
    end else begin
      tx_state_q <= tx_state_d;
      tx_cnt_q <= tx_cnt_d;
      txs_q <= txs_d;
      tx_line_q <= tx_line_d;
      tx_par_q <= tx_par_d;
      txbf_q <= txbf_d;
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  always_comb begin
    rx_state_d = rx_state_q;
    rx_cnt_d = rx_cnt_q;
    rxs_d = rxs_q;
    rx_par_d = rx_par_q;
    rx_perr_d = rx_perr_q;
    unique case (rx_state_q)
      RX_IDLE: begin
        if (!rx_in) begin
          rx_state_d = RX_START;
        end
      end
      RX_START: begin
        if (rx_t.mid) begin
          rx_state_d = rx_in ? RX_IDLE : RX_DATA;
          rx_cnt_d = '0;
          rx_par_d = 1'b0;
          rx_perr_d = 1'b0;
        end
      end
      RX_DATA: begin
        if (rx_t.mid) begin
          rxs_d = rxs_shift;
          rx_par_d = rx_par_q ^ rx_in;
          rx_cnt_d = rx_cnt_q + 4'h1;
          if (rx_cnt_q == last_bit) begin
            rx_state_d = (par_mode == PAR_NONE) ? RX_STOP : RX_PAR;
          end
        end
      end
      RX_PAR: begin
        if (rx_t.mid) begin
          rx_perr_d = rx_par_bad;
          rx_state_d = RX_STOP;
        end
      end
      RX_STOP: begin
        // Only the first stop bit is looked at
        if (rx_t.mid) begin
          rx_state_d = RX_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst || !rx_run) begin
      rx_state_q <= RX_IDLE;
      rx_cnt_q <= '0;
      rxs_q <= BUF_RST;
      rx_par_q <= 1'b0;
      rx_perr_q <= 1'b0;
    end else begin
      rx_state_q <= rx_state_d;
      rx_cnt_q <= rx_cnt_d;
      rxs_q <= rxs_d;
      rx_par_q <= rx_par_d;
      rx_perr_q <= rx_perr_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  rx_lsb7_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    rx_load && !mode_q[MODE_CL] && !msb_first |=> (rxb_q[7] == 1'b0)
  ) else $error("7-bit lsb-first receive left bit 7 set");

  rx_msb7_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    rx_load && !mode_q[MODE_CL] && msb_first |=> (rxb_q[0] == 1'b0)
  ) else $error("7-bit msb-first receive left bit 0 set");

  rx_overrun_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    rx_end && rxb_full_q && !rd_rxb && rx_run
      |=> $stable(rxb_q) && err_q[ERR_OVE]
  ) else $error("overrun character reached the buffer");

  rxb_readonly_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    reg_wr && (reg_addr == ADDR_RXB) && !rx_load && power |=> $stable(rxb_q)
  ) else $error("receive buffer changed on a write");

  tx_start_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    tx_run && (tx_state_q == TX_IDLE) && wr_txb && power && mode_q[MODE_TXE]
      |=> (tx_state_q == TX_START) ##1 (serial_out_pin == $past(transmit_invert))
  ) else $error("transmit did not start after buffer write");

  power_off_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    !power |=> (rxb_q == BUF_RST) && (err_q == ERR_CLEAR) && !txbf_q
  ) else $error("power off left state behind");

  idle_pin_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    !power && !transmit_invert |=> serial_out_pin
  ) else $error("output not high while unpowered");

  tx_disable_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    !mode_q[MODE_TXE] |-> ##2 (tx_state_q == TX_IDLE) && !txbf_q
  ) else $error("transmitter not reset after disable");

  zero_par_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    (par_mode == PAR_ZERO) && $stable(par_mode) |=> !rx_perr_q
  ) else $error("parity flagged in zero parity mode");

  err_route_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    rx_end && err_any && !mode_q[MODE_ISRM] |=> receive_error_irq && !receive_done_irq
  ) else $error("error not routed to error interrupt");

  frame_err_a: assert property (
    @(posedge clk) disable iff (sys_rst)
    rx_end && !rx_in && rx_run |=> err_q[ERR_FE]
  ) else $error("missing stop bit not flagged");

endmodule : serial_transceiver

// *** hw/uart_pkg.sv ***
// Shared constants, register map and state types of the serial transceiver
package uart_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_MODE = 16'hff50;
  localparam logic [15:0] ADDR_TXB = 16'hff51;
  localparam logic [15:0] ADDR_RXB = 16'hff52;
  localparam logic [15:0] ADDR_ERR = 16'hff53;
  localparam logic [15:0] ADDR_TXST = 16'hff55;

  localparam logic [7:0] MODE_RST = 8'h01;
  localparam logic [7:0] BUF_RST = 8'hff;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  localparam logic [2:0] ERR_CLEAR = 3'h0;
  localparam logic [4:0] ERR_PAD = 5'h00;
  localparam logic [5:0] TXST_PAD = 6'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MODE_POWER = 7;
  localparam int MODE_TXE = 6;
  localparam int MODE_RXE = 5;
  localparam int MODE_PAR_HI = 4;
  localparam int MODE_PAR_LO = 3;
  localparam int MODE_CL = 2;
  localparam int MODE_SL = 1;
  localparam int MODE_ISRM = 0;
  localparam int ERR_PE = 2;
  localparam int ERR_FE = 1;
  localparam int ERR_OVE = 0;

  // ----------------------------------------------------------------
  // Modes and counts
  // ----------------------------------------------------------------
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ZERO = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  localparam logic [1:0] PAR_EVEN = 2'h3;
  localparam logic [3:0] LAST_BIT_7 = 4'h6;
  localparam logic [3:0] LAST_BIT_8 = 4'h7;
  localparam logic [1:0] LAST_STOP_1 = 2'h0;
  localparam logic [1:0] LAST_STOP_2 = 2'h1;
  localparam int DIV_K_DEFAULT = 255;
  localparam int DIV_K_MIN = 4;
  localparam int DIV_K_MAX = 255;

  typedef enum logic [4:0] {
    TX_IDLE = 5'h01,
    TX_START = 5'h02,
    TX_DATA = 5'h04,
    TX_PAR = 5'h08,
    TX_STOP = 5'h10
  } tx_state_t;

  typedef enum logic [4:0] {
    RX_IDLE = 5'h01,
    RX_START = 5'h02,
    RX_DATA = 5'h04,
    RX_PAR = 5'h08,
    RX_STOP = 5'h10
  } rx_state_t;

endpackage : uart_pkg

// *** tb/serial_node.sv ***
// Remote serial node model: sends frames and captures frames
`timescale 1ns/1ps
module serial_node #(
  parameter int BIT_CLKS = 8
) (
  input wire logic clk,
  input wire logic line_in,
  output logic line_out
);
  // ----------------------------------------------------------------
  // Line driver
  // ----------------------------------------------------------------
  // Idle high, so enabling reception never sees a false start
  initial line_out = 1'b1;

  task automatic send(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      line_out <= f[i];
      repeat (BIT_CLKS) @(negedge clk);
    end
    line_out <= 1'b1;
  endtask : send

  // ----------------------------------------------------------------
  // Frame capture
  // ----------------------------------------------------------------
  // Returns at mid last bit so a following start is not missed
  task automatic grab(output logic [11:0] g, input int n);
    int k;
    g = '1;
    k = 0;
    while (line_in !== 1'b0 && k < 400) begin
      @(negedge clk);
      k++;
    end
    repeat (BIT_CLKS / 2) @(negedge clk);
    for (int i = 0; i < n; i++) begin
      g[i] = line_in;
      if (i < n - 1) repeat (BIT_CLKS) @(negedge clk);
    end
  endtask : grab
endmodule : serial_node

// *** tb/tb.sv ***
// Self-checking bench of the serial transceiver with a remote node model
`timescale 1ns/1ps
module tb
  import uart_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  // Short divisor keeps frames at 8 clocks a bit
  localparam int K = 4;
  localparam int BC = 2 * K;
  localparam int LIMIT = 10000;
  typedef struct packed {logic msb; logic [4:0] fmt; logic [7:0] d;} row_t;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic serial_in_pin;
  logic serial_out_pin;
  logic transmit_invert = 1'b0;
  logic msb_first = 1'b0;
  logic transmit_done_irq;
  logic receive_done_irq;
  logic receive_error_irq;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  int n_txi = 0;
  int n_rxi = 0;
  int n_rei = 0;
  int n, k, t0, r0, e0;
  logic [11:0] f, f2, g, g2;
  logic [7:0] v;
  // Rows: msb first, mode bits 4:0, data
  row_t rows [8] = '{14'h04a5, 14'h083c, 14'h3696, 14'h38e7,
                     14'h1e01, 14'h2280, 14'h107f, 14'h2d5a};

  serial_transceiver #(.DIV_K(K)) serial_transceiver_inst (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
    .transmit_invert(transmit_invert), .msb_first(msb_first),
    .transmit_done_irq(transmit_done_irq), .receive_done_irq(receive_done_irq),
    .receive_error_irq(receive_error_irq));
  serial_node #(.BIT_CLKS(BC)) serial_node_inst (
    .clk(clk), .line_in(serial_out_pin), .line_out(serial_in_pin));

  always #20 clk = ~clk;

  // Mid-cycle sampling keeps the pulse counters clear of the launching edge
  always @(negedge clk) begin
    cyc++;
    if (transmit_done_irq === 1'b1) n_txi++;
    if (receive_done_irq === 1'b1) n_rxi++;
    if (receive_error_irq === 1'b1) n_rei++;
    if (cyc == LIMIT) begin
      n_mismatch++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Extra edge at the end so back-to-back writes never retoggle in one step
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    @(negedge clk);
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask : rd

  task automatic rchk(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] x;
    rd(a, x);
    chk({4'h0, x}, {4'h0, e});
  endtask : rchk

  task automatic mark();
    t0 = n_txi;
    r0 = n_rxi;
    e0 = n_rei;
  endtask : mark

  function automatic logic [11:0] irqs();
    return 12'(n_txi - t0 + 2 * (n_rxi - r0) + 4 * (n_rei - e0));
  endfunction : irqs

  function automatic int build(input logic [7:0] d, input logic [4:0] m, input logic msb,
                               output logic [11:0] fr, output logic [7:0] ex);
    int nb;
    nb = 1;
    ex = m[MODE_CL] ? d : (msb ? {d[7:1], 1'b0} : {1'b0, d[6:0]});
    fr = '1;
    fr[0] = 1'b0;
    for (int i = 0; i < (m[MODE_CL] ? 8 : 7); i++) begin
      fr[nb] = msb ? ex[7 - i] : ex[i];
      nb++;
    end
    if (m[4:3] != PAR_NONE) begin
      fr[nb] = (m[4:3] == PAR_ZERO) ? 1'b0 : ((m[4:3] == PAR_ODD) ? ~^ex : ^ex);
      nb++;
    end
    return nb + (m[MODE_SL] ? 2 : 1);
  endfunction : build

  task automatic setup(input logic [4:0] fmt, input logic msb);
    wr(ADDR_MODE, {3'b100, fmt});
    msb_first = msb;
    repeat (3) @(negedge clk);
    wr(ADDR_MODE, {3'b111, fmt});
    repeat (2) @(negedge clk);
  endtask : setup

  // In 8-bit formats bit 9 is the parity bit, or the stop bit when there is no parity
  task automatic flip(input logic [4:0] fmt, input logic [7:0] e, input logic [11:0] q);
    setup(fmt, 1'b0);
    n = build(8'h33, fmt, 1'b0, f, v);
    f[9] = ~f[9];
    mark();
    serial_node_inst.send(f, n);
    repeat (2) @(negedge clk);
    rchk(ADDR_ERR, e);
    chk(irqs(), q);
    rd(ADDR_RXB, v);
    rchk(ADDR_ERR, 8'h00);
  endtask : flip

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    rchk(ADDR_MODE, MODE_RST);
    rchk(ADDR_TXB, BUF_RST);
    rchk(ADDR_RXB, BUF_RST);
    rchk(ADDR_ERR, 8'h00);
    rchk(16'hff00, RD_UNMAPPED);
    wr(ADDR_RXB, 8'h55);
    rchk(ADDR_RXB, BUF_RST);
    foreach (rows[r]) begin
      setup(rows[r].fmt, rows[r].msb);
      n = build(rows[r].d, rows[r].fmt, rows[r].msb, f, v);
      mark();
      wr(ADDR_TXB, rows[r].d);
      serial_node_inst.grab(g, n);
      chk(g, f);
      repeat (BC) @(negedge clk);
      rchk(ADDR_TXB, rows[r].d);
      serial_node_inst.send(f, n - int'(rows[r].fmt[MODE_SL]));
      repeat (2) @(negedge clk);
      rchk(ADDR_RXB, v);
      rchk(ADDR_ERR, 8'h00);
      chk(irqs(), 12'h003);
    end
    flip(5'h14, 8'h04, 12'h004);
    flip(5'h0c, 8'h00, 12'h002);
    flip(5'h05, 8'h02, 12'h002);
    // Two-stop format, frames sent with one stop and no gap
    setup(5'h06, 1'b0);
    mark();
    n = build(8'h11, 5'h06, 1'b0, f, v);
    serial_node_inst.send(f, n - 1);
    n = build(8'h22, 5'h06, 1'b0, f, v);
    serial_node_inst.send(f, n - 1);
    repeat (2) @(negedge clk);
    rchk(ADDR_ERR, 8'h01);
    chk(irqs(), 12'h006);
    rchk(ADDR_RXB, 8'h11);
    wr(ADDR_RXB, 8'h55);
    rchk(ADDR_RXB, 8'h11);
    n = build(8'hc3, 5'h06, 1'b0, f, v);
    k = build(8'h3c, 5'h06, 1'b0, f2, v);
    mark();
    fork
      begin
        serial_node_inst.grab(g, n);
        serial_node_inst.grab(g2, n);
      end
      begin
        wr(ADDR_TXB, 8'hc3);
        for (k = 0; k < 20; k++) begin
          rd(ADDR_TXST, v);
          if (v[1] === 1'b0) break;
        end
        wr(ADDR_TXB, 8'h3c);
        rchk(ADDR_TXST, 8'h03);
      end
    join
    repeat (BC) @(negedge clk);
    chk(g, f);
    chk(g2, f2);
    chk(irqs(), 12'h002);
    wr(ADDR_TXB, 8'h00);
    repeat (3 * BC) @(negedge clk);
    chk({11'h0, serial_out_pin}, 12'h000);
    wr(ADDR_MODE, 8'ha4);
    repeat (2) @(negedge clk);
    chk({11'h0, serial_out_pin}, 12'h001);
    rchk(ADDR_TXST, 8'h00);
    n = build(8'h44, 5'h04, 1'b0, f, v);
    serial_node_inst.send(f, n);
    rchk(ADDR_RXB, 8'h44);
    wr(ADDR_MODE, 8'he4);
    repeat (3) @(negedge clk);
    // A new value: the buffer already holds zero
    wr(ADDR_TXB, 8'h0f);
    repeat (3 * BC) @(negedge clk);
    wr(ADDR_MODE, 8'h00);
    repeat (2) @(negedge clk);
    chk({11'h0, serial_out_pin}, 12'h001);
    rchk(ADDR_RXB, BUF_RST);
    rchk(ADDR_ERR, 8'h00);
    rchk(ADDR_TXST, 8'h00);
    transmit_invert = 1'b1;
    repeat (2) @(negedge clk);
    chk({11'h0, serial_out_pin}, 12'h000);
    close_out();
  end
endmodule : tb
